// ### design/ccs_pkg.sv
`default_nettype none
package ccs_pkg;
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned CLK_PERIOD_NS = 40;
   // Compare window width with internal clock
   localparam int unsigned INT_WIN_NS = 10;
   localparam logic [7:0] INT_WIN_CYC = ((INT_WIN_NS / CLK_PERIOD_NS) < 1)
      ? 8'h01 : 8'(INT_WIN_NS / CLK_PERIOD_NS);
   localparam int unsigned AUTOARM_1S_CYC = CLK_HZ;
   localparam int unsigned AUTOARM_3S_CYC = 3 * CLK_HZ;

   localparam int ADDR_W = 14;
   localparam logic [13:0] MEM_LAST = 14'h3fff;
   localparam int DATA_W = 16;

   // AXI4-Lite register byte offsets
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_CMD     = 8'h04;
   localparam logic [7:0] REG_TWORD   = 8'h08;
   localparam logic [7:0] REG_TMASK   = 8'h0c;
   localparam logic [7:0] REG_TDELAY  = 8'h10;
   localparam logic [7:0] REG_SDELAY  = 8'h14;
   localparam logic [7:0] REG_CLKWIN  = 8'h18;
   localparam logic [7:0] REG_STATUS  = 8'h1c;
   localparam logic [7:0] REG_RDADDR  = 8'h20;
   localparam logic [7:0] REG_RDDATA  = 8'h24;
   localparam logic [7:0] REG_EXPECT  = 8'h28;

   // CTRL fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_TSEL_LSB = 2;
   localparam int CTRL_ARM_EN   = 4;
   localparam int CTRL_AA_LSB   = 5;
   localparam int CTRL_AA_ERR   = 7;
   localparam int CTRL_STOP_LSB = 8;
   localparam int CTRL_SOE      = 10;
   localparam int CTRL_EXT_CLK  = 11;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   // CMD bits (write one to pulse)
   localparam int CMD_RUN = 0;
   localparam int CMD_SAMPLE = 1;
   localparam int CMD_STOP = 2;

   localparam logic [1:0] AXI_OKAY = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      CCS_IDLE   = 2'b00,
      CCS_ARMED  = 2'b01,
      CCS_ACTIVE = 2'b10
   } ccs_state_t;

   typedef enum logic [1:0] {
      CCS_M_TSTART = 2'b00,
      CCS_M_TSTOP  = 2'b01,
      CCS_M_CMP    = 2'b10,
      CCS_M_RSV    = 2'b11
   } ccs_mode_t;

   typedef enum logic [1:0] {
      CCS_T_ARM  = 2'b00,
      CCS_T_WORD = 2'b01,
      CCS_T_QUAL = 2'b10,
      CCS_T_RSV  = 2'b11
   } ccs_tsel_t;

   typedef enum logic [1:0] {
      CCS_AA_OFF = 2'b00,
      CCS_AA_0S  = 2'b01,
      CCS_AA_1S  = 2'b10,
      CCS_AA_3S  = 2'b11
   } ccs_aa_t;

   typedef enum logic [1:0] {
      CCS_S_OFF = 2'b00,
      CCS_S_INT = 2'b01,
      CCS_S_EXT = 2'b10,
      CCS_S_RSV = 2'b11
   } ccs_stop_t;

   // Sampled inputs from the unit under test
   typedef struct packed {
      logic              clk_edge;
      logic              arm;
      logic              qual;
      logic              stop;
      logic [DATA_W-1:0] data;
   } ccs_probe_t;
endpackage
`default_nettype wire

// ### design/ccs_seq.sv
`default_nettype none
// Contract
// - Idle arms on run, autoarm, enabled arm
// - Armed searches selected trigger condition
// - Start capture after trigger delay expires
// - Sample command forces active state
// - No clock: one pulse per sample
// - Start mode: stop returns to idle
// - Ascending addresses from zero, readable meanwhile
// - Stop mode: capture from first edge
// - Stop mode: arm input not arming
// - Stop mode armed waits first edge
// - Stop mode: sample toggles idle/active
// - Stop mode: autoarm delay rearms idle
// - Stop mode: trigger plus delay ends
// - Stop mode: wrap buffer, delay selects segment
// - Compare window from clock delay/width
// - Compare: trigger start, stop end
// - Compare begins after trigger delay
// - Compare stop: idle or armed
// - Zero autoarm delay rearms immediately
// - Internal stop counts clocks after active
// - Stop on error one period later
module ccs_seq
   import ccs_pkg::*;
#(
   parameter int unsigned AA1_CYC = AUTOARM_1S_CYC,
   parameter int unsigned AA3_CYC = AUTOARM_3S_CYC
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire ccs_probe_t        probe,
   input  wire logic [31:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [31:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output ccs_state_t             state_o,
   output logic                   sample_clk_o,
   output logic                   cmp_win_o,
   output logic                   err_o
);
   logic [31:0]       ctrl_q;
   logic [DATA_W-1:0] tword_q, tmask_q, expect_q;
   logic [15:0]       tdelay_q;
   logic [13:0]       sdelay_q;
   logic [15:0]       clkwin_q;
   logic [13:0]       rdaddr_q;
   logic              run_p, samp_p, stop_p;
   logic [31:0]       wdat_q;
   logic [7:0]        waddr_q, raddr_q;
   logic              aw_have_q, w_have_q;
   ccs_state_t        state_q, state_d;
   logic [15:0]       tdcnt_q;
   logic              tdrun_q;
   logic [13:0]       sdcnt_q;
   logic              sdrun_q;
   logic [13:0]       wptr_q;
   logic [14:0]       stored_q;
   logic [31:0]       aacnt_q;
   logic              aawait_q, err_q, errstop_q, samp_seen_q;
   logic [DATA_W-1:0] mem [0:16383];
   logic [DATA_W-1:0] rd_word_q;

   ccs_mode_t mode;
   ccs_tsel_t tsel;
   ccs_aa_t   aa;
   ccs_stop_t stsel;
   logic      edge_i, trig_hit, stop_hit, sampling, wr_en, mismatch;
   logic      pulse_sample, aa_enabled, end_cap;
   logic [31:0] aa_len;

   assign mode  = ccs_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
   assign tsel  = ccs_tsel_t'(ctrl_q[CTRL_TSEL_LSB +: 2]);
   assign aa    = ccs_aa_t'(ctrl_q[CTRL_AA_LSB +: 2]);
   assign stsel = ccs_stop_t'(ctrl_q[CTRL_STOP_LSB +: 2]);
   assign aa_enabled = (aa != CCS_AA_OFF) && !(ctrl_q[CTRL_AA_ERR] && err_q);
   assign aa_len = (aa == CCS_AA_3S) ? AA3_CYC : AA1_CYC;

   // Manual sample makes one clock when no external clock
   assign pulse_sample = sample_clk_o;
   assign edge_i = ctrl_q[CTRL_EXT_CLK] ? probe.clk_edge : pulse_sample;

   always_comb begin
      unique case (tsel)
         CCS_T_ARM:  trig_hit = probe.arm;
         CCS_T_WORD: trig_hit = edge_i &&
            ((probe.data & tmask_q) == (tword_q & tmask_q));
         CCS_T_QUAL: trig_hit = edge_i && probe.qual &&
            ((probe.data & tmask_q) == (tword_q & tmask_q));
         default:    trig_hit = 1'b0;
      endcase
   end

   assign mismatch = (mode == CCS_M_CMP) && (state_q == CCS_ACTIVE) &&
      !tdrun_q && edge_i && (probe.data != expect_q);
   assign sampling = (state_q == CCS_ACTIVE) && edge_i &&
      ((mode == CCS_M_TSTOP) || !tdrun_q);
   assign wr_en = sampling;

   // Stop sources: command in all modes, delay/full/error for start and compare modes, trigger delay for stop mode
   always_comb begin
      stop_hit = stop_p;
      if (state_q == CCS_ACTIVE && mode != CCS_M_TSTOP) begin
         if (stsel != CCS_S_OFF && sdrun_q && sdcnt_q == 14'h0000)
            stop_hit = 1'b1;
         if (sampling && wptr_q == MEM_LAST)
            stop_hit = 1'b1;
         if (errstop_q)
            stop_hit = 1'b1;
      end
      if (state_q == CCS_ACTIVE && mode == CCS_M_TSTOP && tdrun_q &&
          tdcnt_q == 16'h0000)
         stop_hit = 1'b1;
   end
   assign end_cap = (state_q == CCS_ACTIVE) && stop_hit;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         CCS_IDLE: begin
            if (samp_p)
               state_d = CCS_ACTIVE;
            else if (run_p || (aa_enabled && !aawait_q))
               state_d = CCS_ARMED;
            else if (mode != CCS_M_TSTOP && ctrl_q[CTRL_ARM_EN] &&
                     probe.arm)
               state_d = CCS_ARMED;
            else if (aawait_q && aacnt_q == 32'h0)
               state_d = CCS_ARMED;
         end
         CCS_ARMED: begin
            if (samp_p)
               state_d = CCS_ACTIVE;
            else if (stop_p)
               state_d = CCS_IDLE;
            else if (mode == CCS_M_TSTOP) begin
               if (edge_i)
                  state_d = CCS_ACTIVE;
            end else if (trig_hit)
               state_d = CCS_ACTIVE;
         end
         CCS_ACTIVE: begin
            if (mode == CCS_M_TSTOP && samp_p)
               state_d = CCS_IDLE;
            else if (end_cap) begin
               if (aa_enabled && aa == CCS_AA_0S)
                  state_d = CCS_ARMED;
               else if (mode == CCS_M_CMP && aa_enabled && !stop_p)
                  state_d = CCS_ARMED;
               else
                  state_d = CCS_IDLE;
            end
         end
         default: state_d = CCS_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         state_q <= CCS_IDLE;
      else
         state_q <= state_d;
   end

   // Autoarm delay timer, armed on capture end into idle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         aawait_q <= 1'b0;
         aacnt_q  <= 32'h0;
      end else if (end_cap && state_d == CCS_IDLE && aa_enabled &&
                   aa != CCS_AA_0S && !stop_p) begin
         aawait_q <= 1'b1;
         aacnt_q  <= aa_len - 32'h1;
      end else if (state_d != CCS_IDLE || !aa_enabled) begin
         aawait_q <= 1'b0;
      end else if (aawait_q && aacnt_q != 32'h0) begin
         aacnt_q <= aacnt_q - 32'h1;
      end
   end

   // Trigger delay counter
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tdcnt_q <= 16'h0;
         tdrun_q <= 1'b0;
      end else if (state_q == CCS_ARMED && state_d == CCS_ACTIVE) begin
         tdcnt_q <= tdelay_q;
         tdrun_q <= (mode != CCS_M_TSTOP) && !samp_p && tdelay_q != 16'h0;
      end else if (state_q == CCS_ACTIVE && mode == CCS_M_TSTOP &&
                   !tdrun_q && trig_hit) begin
         tdcnt_q <= tdelay_q;
         tdrun_q <= 1'b1;
      end else if (state_q == CCS_IDLE && state_d == CCS_ACTIVE) begin
         tdrun_q <= 1'b0;
      end else if (tdrun_q && edge_i && tdcnt_q != 16'h0) begin
         tdcnt_q <= tdcnt_q - 16'h1;
         if (tdcnt_q == 16'h1 && mode != CCS_M_TSTOP)
            tdrun_q <= 1'b0;
      end
   end

   // Stop delay counter
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sdcnt_q <= 14'h0;
         sdrun_q <= 1'b0;
      end else if (state_q != CCS_ACTIVE) begin
         sdcnt_q <= sdelay_q;
         sdrun_q <= 1'b0;
      end else if (!sdrun_q && (stsel == CCS_S_INT ||
                   (stsel == CCS_S_EXT && probe.stop)) && !tdrun_q) begin
         sdrun_q <= 1'b1;
      end else if (sdrun_q && sampling && sdcnt_q != 14'h0) begin
         sdcnt_q <= sdcnt_q - 14'h1;
      end
   end

   // Error latch and stop-on-error
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         err_q     <= 1'b0;
         errstop_q <= 1'b0;
      end else begin
         errstop_q <= mismatch && ctrl_q[CTRL_SOE];
         if (mismatch)
            err_q <= 1'b1;
         else if (run_p)
            err_q <= 1'b0;
      end
   end

   // Write pointer and memory
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wptr_q      <= 14'h0;
         stored_q    <= 15'h0;
         samp_seen_q <= 1'b0;
      end else if (state_q != CCS_ACTIVE && state_d == CCS_ACTIVE &&
                   !(state_q == CCS_IDLE && mode == CCS_M_TSTOP &&
                     samp_seen_q)) begin
         wptr_q      <= 14'h0;
         stored_q    <= 15'h0;
         samp_seen_q <= samp_p;
      end else if (wr_en) begin
         wptr_q <= wptr_q + 14'h1;
         if (stored_q != 15'h4000)
            stored_q <= stored_q + 15'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (wr_en)
         mem[wptr_q] <= probe.data;
      rd_word_q <= mem[rdaddr_q];
   end

   // Compare window generator
   logic [7:0] wdly_q, wwid_q;
   logic       wpend_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wdly_q    <= 8'h0;
         wwid_q    <= 8'h0;
         wpend_q   <= 1'b0;
         cmp_win_o <= 1'b0;
      end else if (mode == CCS_M_CMP && state_q == CCS_ACTIVE && edge_i) begin
         wdly_q  <= ctrl_q[CTRL_EXT_CLK] ? clkwin_q[7:0] : 8'h0;
         wwid_q  <= ctrl_q[CTRL_EXT_CLK] ? clkwin_q[15:8] : INT_WIN_CYC;
         wpend_q <= 1'b1;
         cmp_win_o <= 1'b0;
      end else if (wpend_q && wdly_q != 8'h0) begin
         wdly_q <= wdly_q - 8'h1;
      end else if (wpend_q) begin
         wpend_q   <= 1'b0;
         cmp_win_o <= wwid_q != 8'h0;
      end else if (cmp_win_o) begin
         wwid_q <= wwid_q - 8'h1;
         cmp_win_o <= wwid_q > 8'h1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_o      <= CCS_IDLE;
         sample_clk_o <= 1'b0;
         err_o        <= 1'b0;
      end else begin
         state_o      <= state_d;
         sample_clk_o <= samp_p && !ctrl_q[CTRL_EXT_CLK];
         err_o        <= err_q;
      end
   end

   // AXI4-Lite write channel
   logic do_wr;
   assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         waddr_q       <= 8'h0;
         wdat_q        <= 32'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= AXI_OKAY;
      end else begin
         s_axi_awready <= !aw_have_q && !s_axi_awready;
         s_axi_wready  <= !w_have_q && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            waddr_q   <= s_axi_awaddr[7:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdat_q   <= s_axi_wdata;
         end
         if (do_wr) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (waddr_q <= REG_EXPECT && waddr_q[1:0] == 2'b00)
               ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_bready && s_axi_bvalid) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q   <= CTRL_RST;
         tword_q  <= '0;
         tmask_q  <= '0;
         expect_q <= '0;
         tdelay_q <= 16'h0;
         sdelay_q <= 14'h0;
         clkwin_q <= 16'h0;
         rdaddr_q <= 14'h0;
         run_p    <= 1'b0;
         samp_p   <= 1'b0;
         stop_p   <= 1'b0;
      end else begin
         run_p  <= 1'b0;
         samp_p <= 1'b0;
         stop_p <= 1'b0;
         if (do_wr) begin
            unique case (waddr_q)
               REG_CTRL:   ctrl_q   <= wdat_q;
               REG_CMD: begin
                  run_p  <= wdat_q[CMD_RUN];
                  samp_p <= wdat_q[CMD_SAMPLE];
                  stop_p <= wdat_q[CMD_STOP];
               end
               REG_TWORD:  tword_q  <= wdat_q[DATA_W-1:0];
               REG_TMASK:  tmask_q  <= wdat_q[DATA_W-1:0];
               REG_TDELAY: tdelay_q <= wdat_q[15:0];
               REG_SDELAY: sdelay_q <= wdat_q[13:0];
               REG_CLKWIN: clkwin_q <= wdat_q[15:0];
               REG_RDADDR: rdaddr_q <= wdat_q[13:0];
               REG_EXPECT: expect_q <= wdat_q[DATA_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= AXI_OKAY;
         raddr_q       <= 8'h0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            raddr_q      <= s_axi_araddr[7:0];
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= AXI_OKAY;
            unique case (s_axi_araddr[7:0])
               REG_CTRL:   s_axi_rdata <= ctrl_q;
               REG_CMD:    s_axi_rdata <= 32'h0;
               REG_TWORD:  s_axi_rdata <= 32'(tword_q);
               REG_TMASK:  s_axi_rdata <= 32'(tmask_q);
               REG_TDELAY: s_axi_rdata <= 32'(tdelay_q);
               REG_SDELAY: s_axi_rdata <= 32'(sdelay_q);
               REG_CLKWIN: s_axi_rdata <= 32'(clkwin_q);
               REG_STATUS: s_axi_rdata <= {12'h0, err_q, tdrun_q, stored_q,
                                           1'b0, state_q};
               REG_RDADDR: s_axi_rdata <= 32'(rdaddr_q);
               REG_RDDATA: s_axi_rdata <= 32'(rd_word_q);
               REG_EXPECT: s_axi_rdata <= 32'(expect_q);
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= AXI_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // ccs_seq
`default_nettype wire

// ### verif/ccs_dut_model.sv
`default_nettype none
module ccs_dut_model
   import ccs_pkg::*;
(
   input wire logic              clock,
   input wire logic              rst_n,
   input wire logic              go,
   input wire logic [7:0]        n_edges,
   input wire logic [2:0]        lvl,
   input wire logic [DATA_W-1:0] word,
   output ccs_probe_t            probe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_q;
   logic       edge_q;
   // Edges still owed
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n) cnt_q <= 8'h00;
      else if (go) cnt_q <= n_edges;
      else if (edge_q) cnt_q <= cnt_q - 8'h01;
   // One-cycle edge pulse every other cycle
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n) edge_q <= 1'b0;
      else edge_q <= (cnt_q != 8'h00) && !edge_q && !go;
   assign probe = {edge_q, lvl, word};
endmodule // ccs_dut_model
`default_nettype wire

// ### verif/ccs_seq_checker.sv
`default_nettype none
module ccs_seq_checker
   import ccs_pkg::*;
(
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   input wire ccs_state_t state_o,
   input wire logic       sample_clk_o,
   input wire logic       cmp_win_o,
   input wire logic       err_o
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence resp_due;
      ##2 s_axi_bvalid;
   endsequence
   a_write_resp:
      assert property (wr_taken |-> resp_due)
      else $error("write response not on time");
   a_bvalid_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_read_resp:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response not on time");
   a_rvalid_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read response dropped");
   a_state_legal:
      assert property (state_o != 2'b11)
      else $error("state code out of range");
   a_sample_one:
      assert property ($rose(sample_clk_o) |=> !sample_clk_o)
      else $error("sample pulse longer than one cycle");
   a_window_active:
      assert property (cmp_win_o |-> state_o == CCS_ACTIVE
                       || $past(state_o) == CCS_ACTIVE)
      else $error("compare window outside active");
   a_err_active:
      assert property ($rose(err_o) |-> $past(state_o) == CCS_ACTIVE
                       || $past(state_o, 2) == CCS_ACTIVE)
      else $error("mismatch flagged outside active");
endmodule // ccs_seq_checker

bind ccs_seq ccs_seq_checker i_chk (.clock, .rst_n, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .state_o, .sample_clk_o, .cmp_win_o, .err_o);
`default_nettype wire

// ### verif/ccs_seq_test.sv
`default_nettype none
module ccs_seq_test
   import ccs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock;
   logic        rst_n = 1'b0, go = 1'b0, arm = 1'b0, qual = 1'b0, stop = 1'b0;
   logic [7:0]  n_edges = 8'h00;
   logic [15:0] word = 16'h0000;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
   logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata, rdv;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, sample_clk_o, cmp_win_o, err_o;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   ccs_probe_t  probe;
   ccs_state_t  state_o;
   int          miscompares = 0, check_count = 0, npulse = 0, nwin = 0;

   ccs_seq #(.AA1_CYC(20), .AA3_CYC(60)) i_dut (.clock, .rst_n, .probe,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .state_o, .sample_clk_o, .cmp_win_o, .err_o);
   ccs_dut_model i_model (.clock, .rst_n, .go, .n_edges,
      .lvl({arm, qual, stop}), .word, .probe);

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) if (sample_clk_o === 1'b1) npulse <= npulse + 1;
   always @(posedge clock) if (cmp_win_o === 1'b1) nwin <= nwin + 1;

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, AXI_OKAY}, {30'h0, s_axi_bresp});
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic cfg(input ccs_mode_t m, input ccs_tsel_t t, input logic ae,
                      input ccs_aa_t a, input ccs_stop_t s, input logic se);
      wr(REG_CTRL, {20'h0, 1'b1, se, s, 1'b0, a, ae, t, m});
   endtask
   task automatic edges(input logic [7:0] n);
      @(posedge clock);
      n_edges <= n;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      repeat (2 * n + 1) @(posedge clock);
   endtask
   task automatic st(input ccs_state_t s);
      chk("state", {30'h0, s}, {30'h0, state_o});
   endtask
   task automatic wst(input ccs_state_t s, input int m);
      for (int i = 0; i < m && state_o !== s; i++) @(posedge clock);
      st(s);
   endtask

   task automatic t_regs();
      rd(REG_CTRL);
      chk("ctrl", CTRL_RST, rdv);
      wr(REG_TWORD, 32'h0000_1234);
      rd(REG_TWORD);
      chk("tword", 32'h0000_1234, rdv);
      rd(8'h40);
      chk("resp", {30'h0, AXI_SLVERR}, {30'h0, rsp});
      chk("unmapped", 32'h0, rdv);
   endtask
   task automatic t_sample();
      int n;
      word <= 16'h5a5a;
      wr(REG_CTRL, 32'h0000_0004);
      n = npulse;
      wr(REG_CMD, 32'h2);
      wst(CCS_ACTIVE, 8);
      repeat (4) @(posedge clock);
      chk("pulses", 32'h1, 32'(npulse - n));
      wr(REG_RDADDR, 32'h0);
      rd(REG_RDDATA);
      chk("mem0", 32'h0000_5a5a, rdv);
      wr(REG_CMD, 32'h4);
      wst(CCS_IDLE, 8);
   endtask
   task automatic t_tstart();
      word <= 16'h1235;
      cfg(CCS_M_TSTART, CCS_T_WORD, 1'b0, CCS_AA_OFF, CCS_S_OFF, 1'b0);
      wr(REG_TMASK, 32'h0000_ffff);
      wr(REG_TDELAY, 32'h2);
      wr(REG_CMD, 32'h1);
      wst(CCS_ARMED, 8);
      edges(2);
      st(CCS_ARMED);
      word <= 16'h1234;
      edges(2);
      rd(REG_STATUS);
      chk("status", 32'h0004_0002, rdv);
      edges(2);
      wst(CCS_ACTIVE, 8);
      rd(REG_STATUS);
      chk("status", 32'h0000_000a, rdv);
      wr(REG_CMD, 32'h4);
      wst(CCS_IDLE, 8);
   endtask
   task automatic t_arm();
      wr(REG_TDELAY, 32'h0);
      cfg(CCS_M_TSTART, CCS_T_ARM, 1'b0, CCS_AA_OFF, CCS_S_OFF, 1'b0);
      arm <= 1'b1;
      repeat (6) @(posedge clock);
      st(CCS_IDLE);
      cfg(CCS_M_TSTART, CCS_T_ARM, 1'b1, CCS_AA_OFF, CCS_S_OFF, 1'b0);
      edges(1);
      wst(CCS_ACTIVE, 8);
      arm <= 1'b0;
      wr(REG_CMD, 32'h4);
      wst(CCS_IDLE, 8);
   endtask
   task automatic t_tstop();
      word <= 16'h0001;
      cfg(CCS_M_TSTOP, CCS_T_WORD, 1'b1, CCS_AA_OFF, CCS_S_OFF, 1'b0);
      arm <= 1'b1;
      repeat (6) @(posedge clock);
      st(CCS_IDLE);
      arm <= 1'b0;
      wr(REG_CMD, 32'h1);
      wst(CCS_ARMED, 8);
      repeat (6) @(posedge clock);
      st(CCS_ARMED);
      edges(1);
      wst(CCS_ACTIVE, 8);
      word <= 16'h1234;
      edges(1);
      wst(CCS_IDLE, 8);
      wr(REG_CMD, 32'h2);
      wst(CCS_ACTIVE, 8);
      wr(REG_CMD, 32'h2);
      wst(CCS_IDLE, 8);
   endtask
   task automatic t_auto();
      cfg(CCS_M_CMP, CCS_T_ARM, 1'b0, CCS_AA_0S, CCS_S_EXT, 1'b0);
      wr(REG_CMD, 32'h1);
      wst(CCS_ARMED, 8);
      arm <= 1'b1;
      edges(1);
      wst(CCS_ACTIVE, 8);
      arm <= 1'b0;
      stop <= 1'b1;
      n_edges <= 8'h02;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      for (int i = 0; i < 12 && state_o === CCS_ACTIVE; i++) @(posedge clock);
      st(CCS_ARMED);
      stop <= 1'b0;
      cfg(CCS_M_CMP, CCS_T_ARM, 1'b0, CCS_AA_OFF, CCS_S_EXT, 1'b0);
      wr(REG_CMD, 32'h4);
      wst(CCS_IDLE, 8);
      word <= 16'h0001;
      cfg(CCS_M_TSTOP, CCS_T_WORD, 1'b0, CCS_AA_1S, CCS_S_OFF, 1'b0);
      wr(REG_CMD, 32'h1);
      wst(CCS_ARMED, 8);
      edges(1);
      wst(CCS_ACTIVE, 8);
      word <= 16'h1234;
      edges(1);
      wst(CCS_IDLE, 8);
      wst(CCS_ARMED, 40);
      cfg(CCS_M_TSTOP, CCS_T_WORD, 1'b0, CCS_AA_OFF, CCS_S_OFF, 1'b0);
      wr(REG_CMD, 32'h4);
      wst(CCS_IDLE, 8);
   endtask
   task automatic t_err();
      int n;
      wr(REG_CLKWIN, 32'h0000_0100);
      word <= 16'h1234;
      wr(REG_EXPECT, 32'h0000_1234);
      cfg(CCS_M_CMP, CCS_T_QUAL, 1'b0, CCS_AA_OFF, CCS_S_OFF, 1'b1);
      wr(REG_CMD, 32'h1);
      wst(CCS_ARMED, 8);
      edges(2);
      st(CCS_ARMED);
      qual <= 1'b1;
      edges(1);
      wst(CCS_ACTIVE, 8);
      n = nwin;
      qual <= 1'b0;
      edges(3);
      chk("err", 32'h0, {31'h0, err_o});
      word <= 16'h0f0f;
      edges(1);
      wst(CCS_IDLE, 8);
      chk("err", 32'h1, {31'h0, err_o});
      repeat (2) @(posedge clock);
      chk("win", 32'h4, 32'(nwin - n));
   endtask

   initial begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_regs();
      t_sample();
      t_tstart();
      t_arm();
      t_tstop();
      t_auto();
      t_err();
      give_verdict();
   end
   initial begin
      repeat (8000) @(posedge clock);
      miscompares++;
      give_verdict();
   end
endmodule // ccs_seq_test
`default_nettype wire
